// ===== core/fprc_rx_ctl.v
// Receive coding control: carrier, alignment, link monitor, far-end fault
//
// The implementer's own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "fprc_regs.vh"
module fprc_rx_ctl #(
  parameter READY_CYC  = `FPRC_T_READY_US * `FPRC_CLK_MHZ,
  parameter SDLOSS_CYC = `FPRC_T_SDLOSS_NS / `FPRC_CLK_NS
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        rx_link_clk,
  input  wire        rx_bit,
  input  wire        external_signal_detect_input,
  input  wire        an_link_enable,
  input  wire        link10_ok,
  input  wire        mii_tx_en,
  input  wire        tx_bit,
  input  wire        fiber_select_strap,
  output reg  [3:0]  rxd_q,
  output reg         rx_dv_q,
  output reg         rx_er_q,
  output reg         crs_q,
  output reg         link_activity_pin,
  output reg         tx_enable_q,
  output reg         tx_line_q
);

  localparam ST_WAIT  = 2'h0;
  localparam ST_READY = 2'h1;
  localparam ST_UP    = 2'h2;
  localparam [15:0] READY_N  = READY_CYC;
  localparam [15:0] SDLOSS_N = SDLOSS_CYC;

  // Translate a code group; bit 4 is the valid flag
  function [4:0] dec5;
    input [4:0] cg;
    begin
      case (cg)
        5'h1e: dec5 = 5'h10;
        5'h09: dec5 = 5'h11;
        5'h14: dec5 = 5'h12;
        5'h15: dec5 = 5'h13;
        5'h0a: dec5 = 5'h14;
        5'h0b: dec5 = 5'h15;
        5'h0e: dec5 = 5'h16;
        5'h0f: dec5 = 5'h17;
        5'h12: dec5 = 5'h18;
        5'h13: dec5 = 5'h19;
        5'h16: dec5 = 5'h1a;
        5'h17: dec5 = 5'h1b;
        5'h1a: dec5 = 5'h1c;
        5'h1b: dec5 = 5'h1d;
        5'h1c: dec5 = 5'h1e;
        5'h1d: dec5 = 5'h1f;
        default: dec5 = 5'h00;
      endcase
    end
  endfunction

  // Two zeros at least two bit times apart anywhere in the window
  function two_nc_zeros;
    input [9:0] w;
    integer i;
    integer j;
    begin
      two_nc_zeros = 1'b0;
      for (i = 0; i < `FPRC_CS_WINDOW; i = i + 1) begin
        for (j = i + 2; j < `FPRC_CS_WINDOW; j = j + 1) begin
          if (!w[i] && !w[j])
            two_nc_zeros = 1'b1;
        end
      end
    end
  endfunction

  // Each of the eight pin and link inputs passes two flops before use
  reg  [7:0]  sync1_q;
  reg  [7:0]  sync2_q;
  reg         lclk_prev_q;
  wire        lclk_s   = sync2_q[7];
  wire        rxb_s    = sync2_q[6];
  wire        extsd_s  = sync2_q[5];
  wire        an_ok_s  = sync2_q[4];
  wire        l10_s    = sync2_q[3];
  wire        txen_s   = sync2_q[2];
  wire        txb_s    = sync2_q[1];
  wire        strap_s  = sync2_q[0];
  wire        bit_ev   = lclk_s & ~lclk_prev_q;

  always @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q     <= 8'h00;
      sync2_q     <= 8'h00;
      lclk_prev_q <= 1'b0;
    end else begin
      sync1_q     <= {rx_link_clk, rx_bit, external_signal_detect_input,
                      an_link_enable, link10_ok, mii_tx_en, tx_bit,
                      fiber_select_strap};
      sync2_q     <= sync1_q;
      lclk_prev_q <= lclk_s;
    end
  end

  // Configuration state
  reg        an_en_q;
  reg        repeater_q;
  reg        fiber_q;
  reg        fefi_en_q;
  reg        ana_low_q;
  reg        rfault_q;
  reg  [1:0] strap_wait_q;
  reg  [1:0] lm_state_q;

  // Descrambler, self-locking on idle outside frames
  reg  [10:0] lfsr_q;
  wire        rxb = fiber_q ? rxb_s : (rxb_s ^ lfsr_q[10]);
  reg  [9:0]  sh_q;
  wire [9:0]  sh_d = {sh_q[8:0], rxb};

  // Receive framing state
  reg        crs_rx_q;
  reg        frame_q;
  reg        bad_q;
  reg  [3:0] bitcnt_q;
  reg  [6:0] ones_q;
  reg  [1:0] fefi_cnt_q;
  reg        fault_rx_q;
  reg        sd_dig_q;
  reg [15:0] sdloss_q;
  reg [15:0] ready_q;
  reg        was_up_q;
  reg        fefi_tx_q;
  reg  [6:0] pat_q;

  wire sig_ok  = (fiber_q && !ana_low_q) ? sd_dig_q : extsd_s;
  wire link_up = (lm_state_q == ST_UP);
  wire rx_run  = link_up && sig_ok && !fault_rx_q;
  wire [4:0] cur_dec = dec5(sh_d[4:0]);
  wire grp_edge = (bitcnt_q == `FPRC_GROUP_BITS - 1);

  always @(posedge aclk) begin
    if (!aresetn) begin
      lfsr_q     <= 11'h000;
      sh_q       <= 10'h3ff;
      crs_rx_q   <= 1'b0;
      frame_q    <= 1'b0;
      bad_q      <= 1'b0;
      bitcnt_q   <= 4'h0;
      rxd_q      <= 4'h0;
      rx_dv_q    <= 1'b0;
      rx_er_q    <= 1'b0;
      ones_q     <= 7'h00;
      fefi_cnt_q <= 2'h0;
      fault_rx_q <= 1'b0;
      sd_dig_q   <= 1'b0;
      sdloss_q   <= 16'h0000;
    end else begin
      if (bit_ev)
        sdloss_q <= 16'h0000;
      else if (sdloss_q != SDLOSS_N)
        sdloss_q <= sdloss_q + 16'h0001;
      if (sdloss_q == SDLOSS_N)
        sd_dig_q <= 1'b0;
      if (!rx_run) begin
        frame_q <= 1'b0;
        bad_q   <= 1'b0;
        crs_rx_q <= 1'b0;
        rx_dv_q <= 1'b0;
        rx_er_q <= 1'b0;
        rxd_q   <= 4'h0;
      end
      if (bit_ev) begin
        sh_q <= sh_d;
        lfsr_q <= frame_q ? {lfsr_q[9:0], lfsr_q[10] ^ lfsr_q[8]}
                          : {lfsr_q[9:0], ~rxb_s};
        if (rxb) begin
          if (ones_q != 7'h7f)
            ones_q <= ones_q + 7'h01;
          if (ones_q == `FPRC_SD_ONES - 1)
            sd_dig_q <= 1'b1;
          if (ones_q == `FPRC_FEFI_ONES + 1)
            fault_rx_q <= 1'b0;
        end else begin
          ones_q <= 7'h00;
          if (fiber_q && ones_q == `FPRC_FEFI_ONES) begin
            if (fefi_cnt_q == `FPRC_FEFI_COUNT - 1)
              fault_rx_q <= 1'b1;
            else
              fefi_cnt_q <= fefi_cnt_q + 2'h1;
          end else begin
            fefi_cnt_q <= 2'h0;
          end
        end
        // Unframed carrier needs the full ten-bit span to judge the delimiter
        bitcnt_q <= (grp_edge && (frame_q || bad_q)) ? 4'h0 : bitcnt_q + 4'h1;
        if (!crs_rx_q) begin
          if (rx_run && two_nc_zeros(sh_d)) begin
            crs_rx_q <= 1'b1;
            bitcnt_q <= 4'h0;
          end
        end else if (sh_d == 10'h3ff) begin
          crs_rx_q <= 1'b0;
          frame_q  <= 1'b0;
          rx_dv_q  <= 1'b0;
          bad_q    <= 1'b0;
          rx_er_q  <= 1'b0;
          rxd_q    <= 4'h0;
        end else if (!frame_q && !bad_q && rx_run) begin
          if (sh_d == {`FPRC_CG_J, `FPRC_CG_K}) begin
            frame_q  <= 1'b1;
            bitcnt_q <= 4'h0;
            rx_dv_q  <= 1'b1;
            rxd_q    <= `FPRC_NIB_PRE;
          end else if (bitcnt_q == `FPRC_CS_WINDOW - 1) begin
            bad_q    <= 1'b1;
            bitcnt_q <= 4'h0;
          end
        end else if (grp_edge && frame_q && rx_run) begin
          if (sh_d == {`FPRC_CG_T, `FPRC_CG_R}) begin
            frame_q <= 1'b0;
            rx_dv_q <= 1'b0;
            rx_er_q <= 1'b0;
            rxd_q   <= 4'h0;
          end else if (sh_d[4:0] != `FPRC_CG_T) begin
            rxd_q   <= cur_dec[3:0];
            rx_er_q <= ~cur_dec[4];
          end
        end else if (grp_edge && bad_q && rx_run) begin
          rx_er_q <= 1'b1;
          rxd_q   <= `FPRC_NIB_BADSSD;
        end
      end
    end
  end

  // Link monitor; any loss of signal restarts from waiting
  always @(posedge aclk) begin
    if (!aresetn) begin
      lm_state_q <= ST_WAIT;
      ready_q    <= 16'h0000;
    end else if (!sig_ok) begin
      lm_state_q <= ST_WAIT;
      ready_q    <= 16'h0000;
    end else begin
      case (lm_state_q)
        ST_WAIT: begin
          if (ready_q == READY_N - 16'h0001)
            lm_state_q <= ST_READY;
          else
            ready_q <= ready_q + 16'h0001;
        end
        ST_READY: begin
          if (an_ok_s || !an_en_q)
            lm_state_q <= ST_UP;
        end
        ST_UP: lm_state_q <= ST_UP;
        default: lm_state_q <= ST_WAIT;
      endcase
    end
  end

  // Transmit side: enable, fault idle and line coding
  wire tx_src = fefi_tx_q ? (pat_q != `FPRC_FEFI_ONES)
              : (tx_enable_q ? txb_s : 1'b1);

  always @(posedge aclk) begin
    if (!aresetn) begin
      was_up_q          <= 1'b0;
      fefi_tx_q         <= 1'b0;
      pat_q             <= 7'h00;
      tx_enable_q       <= 1'b0;
      tx_line_q         <= 1'b0;
      crs_q             <= 1'b0;
      link_activity_pin <= 1'b0;
    end else begin
      tx_enable_q <= link_up && !fault_rx_q && !fefi_tx_q;
      link_activity_pin <= link_up | l10_s;
      crs_q <= rx_run && (crs_rx_q || (!repeater_q && txen_s));
      if (link_up) begin
        was_up_q  <= 1'b1;
        fefi_tx_q <= 1'b0;
      end else if (was_up_q && !sig_ok && fefi_en_q && fiber_q) begin
        fefi_tx_q <= 1'b1;
        was_up_q  <= 1'b0;
      end
      if (bit_ev) begin
        if (fefi_tx_q)
          pat_q <= (pat_q == `FPRC_FEFI_ONES) ? 7'h00 : pat_q + 7'h01;
        else
          pat_q <= 7'h00;
        if (fiber_q)
          tx_line_q <= tx_line_q ^ tx_src;
        else
          tx_line_q <= tx_src;
      end
    end
  end

  // AXI4-Lite register slave
  reg        aw_have_q;
  reg        w_have_q;
  reg  [5:0] aw_idx_q;
  reg [31:0] wdata_q;
  reg  [3:0] wstrb_q;
  wire [5:0] ar_idx = s_axi_araddr[7:2];
  wire       rd_hs  = s_axi_arvalid && s_axi_arready;
  wire       st_rd  = rd_hs && (ar_idx == `FPRC_IDX_STATUS);
  wire       do_wr  = aw_have_q && w_have_q && !s_axi_bvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `FPRC_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= `FPRC_RESP_OKAY;
      s_axi_rdata   <= 32'h0000_0000;
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      aw_idx_q      <= 6'h00;
      wdata_q       <= 32'h0000_0000;
      wstrb_q       <= 4'h0;
      an_en_q       <= `FPRC_RST_AN_EN;
      repeater_q    <= `FPRC_RST_REPEATER;
      ana_low_q     <= `FPRC_RST_ANA_LOW;
      fiber_q       <= 1'b0;
      fefi_en_q     <= 1'b0;
      rfault_q      <= 1'b0;
      strap_wait_q  <= 2'h0;
    end else begin
      // Strap is caught once the synchroniser has filled after release
      if (strap_wait_q != 2'h3) begin
        strap_wait_q <= strap_wait_q + 2'h1;
        if (strap_wait_q == 2'h2) begin
          fiber_q   <= strap_s;
          fefi_en_q <= strap_s;
        end
      end
      s_axi_awready <= s_axi_awvalid && !aw_have_q && !s_axi_awready;
      s_axi_wready  <= s_axi_wvalid && !w_have_q && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_idx_q  <= s_axi_awaddr[7:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `FPRC_RESP_OKAY;
        case (aw_idx_q)
          `FPRC_IDX_CONFIG: begin
            if (wstrb_q[0]) begin
              an_en_q    <= wdata_q[`FPRC_CF_AN_EN];
              repeater_q <= wdata_q[`FPRC_CF_REPEATER];
              fiber_q    <= wdata_q[`FPRC_CF_FIBER];
              fefi_en_q  <= wdata_q[`FPRC_CF_FEFI_EN];
            end
          end
          `FPRC_IDX_SDCTL: begin
            if (wstrb_q[0])
              ana_low_q <= wdata_q[`FPRC_SD_ANA_LOW];
          end
          `FPRC_IDX_STATUS: s_axi_bresp <= `FPRC_RESP_OKAY;
          default: s_axi_bresp <= `FPRC_RESP_SLVERR;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (rd_hs) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `FPRC_RESP_OKAY;
        s_axi_rdata  <= 32'h0000_0000;
        case (ar_idx)
          `FPRC_IDX_STATUS: begin
            s_axi_rdata[`FPRC_ST_LINK]   <= link_up | l10_s;
            s_axi_rdata[`FPRC_ST_RFAULT] <= rfault_q;
          end
          `FPRC_IDX_CONFIG: begin
            s_axi_rdata[`FPRC_CF_AN_EN]    <= an_en_q;
            s_axi_rdata[`FPRC_CF_REPEATER] <= repeater_q;
            s_axi_rdata[`FPRC_CF_FIBER]    <= fiber_q;
            s_axi_rdata[`FPRC_CF_FEFI_EN]  <= fefi_en_q;
          end
          `FPRC_IDX_SDCTL: s_axi_rdata[`FPRC_SD_ANA_LOW] <= ana_low_q;
          default: s_axi_rresp <= `FPRC_RESP_SLVERR;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      // A new fault detection wins over the clear by a status read
      if (fault_rx_q)
        rfault_q <= 1'b1;
      else if (st_rd)
        rfault_q <= 1'b0;
    end
  end

endmodule // fprc_rx_ctl

// ===== include/fprc_regs.vh
// Constants for the fast ethernet receive coding control block
`ifndef FPRC_REGS_VH
`define FPRC_REGS_VH

// Register indices; byte address is four times the index
`define FPRC_IDX_STATUS    6'h01
`define FPRC_IDX_CONFIG    6'h11
`define FPRC_IDX_SDCTL     6'h18

// Status fields
`define FPRC_ST_LINK       2
`define FPRC_ST_RFAULT     4
// Config fields
`define FPRC_CF_AN_EN      0
`define FPRC_CF_REPEATER   1
`define FPRC_CF_FIBER      2
`define FPRC_CF_FEFI_EN    3
// Signal detect control field
`define FPRC_SD_ANA_LOW    0

`define FPRC_RST_AN_EN     1'b1
`define FPRC_RST_REPEATER  1'b0
`define FPRC_RST_ANA_LOW   1'b0

// AXI responses
`define FPRC_RESP_OKAY     2'h0
`define FPRC_RESP_SLVERR   2'h2

// Timing and counts
`define FPRC_CLK_MHZ       100
`define FPRC_T_READY_US    500
`define FPRC_T_SDLOSS_NS   2000
`define FPRC_CLK_NS        10
`define FPRC_CS_WINDOW     10
`define FPRC_SD_ONES       65
`define FPRC_FEFI_ONES     84
`define FPRC_FEFI_COUNT    3
`define FPRC_GROUP_BITS    5

// Code groups and nibbles
`define FPRC_CG_J          5'h18
`define FPRC_CG_K          5'h11
`define FPRC_CG_T          5'h0d
`define FPRC_CG_R          5'h07
`define FPRC_NIB_PRE       4'h5
`define FPRC_NIB_BADSSD    4'he

`endif

// ===== verification/fprc_rx_ctl_chk.sv
// Assertion checker for the receive coding control block
`timescale 1ns/1ps
`include "fprc_regs.vh"
module fprc_rx_ctl_chk (
  input logic       aclk,
  input logic       aresetn,
  input logic       s_axi_arvalid,
  input logic       s_axi_arready,
  input logic       s_axi_rvalid,
  input logic       link10_ok,
  input logic [3:0] rxd_q,
  input logic       rx_dv_q,
  input logic       rx_er_q,
  input logic       crs_q,
  input logic       link_activity_pin,
  input logic       tx_enable_q
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_dv_in_crs: assert property (rx_dv_q |-> crs_q)
    else $error("valid high without carrier");
  chk_crs_leads: assert property ($rose(rx_dv_q) |-> $past(crs_q))
    else $error("carrier did not lead valid");
  chk_dv_pre: assert property ($rose(rx_dv_q) |->
    rxd_q == `FPRC_NIB_PRE) else $error("first nibble not preamble");
  chk_dv_link: assert property (!tx_enable_q [*3] |-> !rx_dv_q)
    else $error("valid while link stopped");
  chk_er_carrier: assert property (rx_er_q |-> crs_q)
    else $error("error flag without carrier");
  chk_badssd_nib: assert property (rx_er_q && !rx_dv_q |->
    rxd_q == `FPRC_NIB_BADSSD) else $error("bad delimiter nibble wrong");
  chk_reset_low: assert property (disable iff (1'b0)
    !aresetn ##1 !aresetn |-> !rx_dv_q && !rx_er_q && !crs_q && rxd_q == 4'h0)
    else $error("receive outputs not low in reset");
  chk_link_follow: assert property ($rose(link10_ok) |->
    ##[1:5] link_activity_pin) else $error("slow link pin");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |->
    ##[1:2] s_axi_rvalid) else $error("read answer late");

  cov_frame: cover property ($rose(rx_dv_q));
  cov_badssd: cover property (rx_er_q && !rx_dv_q);
  cov_link_loss: cover property ($fell(link_activity_pin));
endmodule // fprc_rx_ctl_chk

bind fprc_rx_ctl fprc_rx_ctl_chk u_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .link10_ok(link10_ok), .rxd_q(rxd_q), .rx_dv_q(rx_dv_q),
  .rx_er_q(rx_er_q), .crs_q(crs_q), .link_activity_pin(link_activity_pin),
  .tx_enable_q(tx_enable_q)
);

// ===== verification/fprc_link_partner.sv
// Link partner model: recovered clock and received bit stream
`timescale 1ns/1ps
module fprc_link_partner (
  output logic link_clk,
  output logic line_bit
);
  logic running = 1'b0;
  logic q[$];

  initial begin
    link_clk = 1'b0;
    line_bit = 1'b1;
  end
  // Clock stands still low while the line is dead
  always #62.5 link_clk = running ? !link_clk : 1'b0;
  // New bit at the falling edge so it is stable at the sampling edge
  always @(negedge link_clk) begin
    if (q.size() > 0)
      line_bit <= q.pop_front();
    else
      line_bit <= 1'b1;
  end

  task automatic start;
    running = 1'b1;
  endtask
  // A released line no longer shows the last bit
  task automatic stop;
    running = 1'b0;
    #130;
    line_bit = !line_bit;
  endtask
  task automatic send_group(input logic [4:0] g);
    for (int i = 4; i >= 0; i--)
      q.push_back(g[i]);
    wait (q.size() == 0);
  endtask
  task automatic send_ones(input int n, input logic tail);
    repeat (n) q.push_back(1'b1);
    if (tail)
      q.push_back(1'b0);
    wait (q.size() == 0);
  endtask
endmodule // fprc_link_partner

// ===== verification/testbench.sv
// Self-checking bench for the receive coding control block
`timescale 1ns/1ps
`include "fprc_regs.vh"
module testbench;
  logic        aclk, aresetn;
  logic [7:0]  aw_addr, ar_addr;
  logic [31:0] w_data, r_data, rd;
  logic        aw_valid, aw_ready, w_valid, w_ready, b_valid, b_ready;
  logic        ar_valid, ar_ready, r_valid, r_ready;
  logic [1:0]  b_resp, r_resp, resp;
  logic        lclk, lbit, an_en, l10, tx_en;
  logic        ext_sd, tx_b, strap;
  logic [3:0]  w_strb;
  int          hold_n;
  logic [3:0]  rxd;
  logic        dv, er, crs, lnk, txe, txl;
  int          num_errors = 0;
  int          n_compared = 0;

  fprc_link_partner partner (.link_clk(lclk), .line_bit(lbit));
  // Short qualification and loss counts keep the run brief
  fprc_rx_ctl #(.READY_CYC(20), .SDLOSS_CYC(40)) dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(aw_addr),
    .s_axi_awvalid(aw_valid), .s_axi_awready(aw_ready),
    .s_axi_wdata(w_data), .s_axi_wstrb(w_strb), .s_axi_wvalid(w_valid),
    .s_axi_wready(w_ready), .s_axi_bresp(b_resp), .s_axi_bvalid(b_valid),
    .s_axi_bready(b_ready), .s_axi_araddr(ar_addr),
    .s_axi_arvalid(ar_valid), .s_axi_arready(ar_ready),
    .s_axi_rdata(r_data), .s_axi_rresp(r_resp), .s_axi_rvalid(r_valid),
    .s_axi_rready(r_ready), .rx_link_clk(lclk), .rx_bit(lbit),
    .external_signal_detect_input(ext_sd), .an_link_enable(an_en),
    .link10_ok(l10), .mii_tx_en(tx_en), .tx_bit(tx_b),
    .fiber_select_strap(strap), .rxd_q(rxd), .rx_dv_q(dv), .rx_er_q(er),
    .crs_q(crs), .link_activity_pin(lnk), .tx_enable_q(txe),
    .tx_line_q(txl)
  );

  always #5 aclk = !aclk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic results;
    $display("compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    aw_addr <= a;
    aw_valid <= 1'b1;
    w_data <= d;
    w_valid <= 1'b1;
    b_ready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (aw_ready === 1'b1)
        aw_valid <= 1'b0;
      if (w_ready === 1'b1)
        w_valid <= 1'b0;
    end while (b_valid !== 1'b1 && n < 200);
    resp = b_resp;
    b_ready <= 1'b0;
  endtask

  task automatic axi_read(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    ar_addr <= a;
    ar_valid <= 1'b1;
    r_ready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (ar_ready === 1'b1)
        ar_valid <= 1'b0;
    end while (r_valid !== 1'b1 && n < 200);
    rd = r_data;
    resp = r_resp;
    r_ready <= 1'b0;
  endtask

  // Lets the last link bit cross the synchronisers, ends before the next
  task automatic settle;
    repeat (11) @(posedge aclk);
  endtask

  task automatic send_jk;
    partner.send_group(`FPRC_CG_J);
    partner.send_group(`FPRC_CG_K);
  endtask

  initial begin
    repeat (60000) @(posedge aclk);
    num_errors++;
    $display("wrong value at %0t: run timed out", $time);
    results();
  end

  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {aw_addr, ar_addr, w_data, aw_valid, w_valid, b_ready} = '0;
    {ar_valid, r_ready, an_en, l10, tx_en} = '0;
    w_strb = 4'hf;
    ext_sd = 1'b0;
    tx_b = 1'b1;
    strap = 1'b1;
    repeat (12) @(posedge aclk);
    check({rxd, dv, er, crs}, 7'h00);
    aresetn <= 1'b1;
    repeat (6) @(posedge aclk);
    axi_read({`FPRC_IDX_CONFIG, 2'b00});
    check(rd, 32'h0000_000d);
    axi_read({`FPRC_IDX_SDCTL, 2'b00});
    check(rd, 32'h0000_0000);
    axi_read(8'h08);
    check(resp, `FPRC_RESP_SLVERR);
    check(rd, 32'h0000_0000);
    partner.start();
    repeat (600) @(posedge aclk);
    check(lnk, 1'b0);
    repeat (600) @(posedge aclk);
    check(lnk, 1'b0);
    an_en <= 1'b1;
    repeat (10) @(posedge aclk);
    check({lnk, txe}, 2'b11);
    axi_read({`FPRC_IDX_STATUS, 2'b00});
    check(rd[`FPRC_ST_LINK], 1'b1);
    @(negedge lclk);
    rd[0] = txl;
    @(negedge lclk);
    check(txl, !rd[0]);
    send_jk();
    settle();
    check({dv, rxd}, {1'b1, `FPRC_NIB_PRE});
    partner.send_group(5'b01110);
    settle();
    check({dv, er, rxd}, 6'h26);
    partner.send_group(5'b00000);
    settle();
    check(er, 1'b1);
    partner.send_group(5'b01001);
    settle();
    check({er, rxd}, 5'h01);
    partner.send_group(`FPRC_CG_T);
    partner.send_group(`FPRC_CG_R);
    settle();
    check({dv, crs}, 2'b01);
    partner.send_ones(10, 1'b0);
    settle();
    check({crs, er}, 2'b00);
    repeat (4) partner.send_group(5'b10101);
    settle();
    check({dv, er, crs, rxd}, {3'b011, `FPRC_NIB_BADSSD});
    partner.send_ones(10, 1'b0);
    settle();
    check({er, crs}, 2'b00);
    send_jk();
    settle();
    check(dv, 1'b1);
    partner.stop();
    repeat (70) @(posedge aclk);
    check({dv, lnk, txe}, 3'b000);
    l10 <= 1'b1;
    repeat (6) @(posedge aclk);
    check(lnk, 1'b1);
    l10 <= 1'b0;
    axi_write({`FPRC_IDX_CONFIG, 2'b00}, 32'h0000_000c);
    check(resp, `FPRC_RESP_OKAY);
    axi_write(8'h08, 32'h0000_00ff);
    check(resp, `FPRC_RESP_SLVERR);
    axi_write({`FPRC_IDX_SDCTL, 2'b00}, 32'h0000_0001);
    an_en <= 1'b0;
    partner.start();
    repeat (300) @(posedge aclk);
    check(lnk, 1'b0);
    // Link held down by the analog detect, so the fault idle keeps going
    @(negedge lclk);
    rd[0] = txl;
    hold_n = 0;
    repeat (85) begin
      @(negedge lclk);
      if (txl == rd[0])
        hold_n++;
      rd[0] = txl;
    end
    check(hold_n, 1);
    @(posedge aclk);
    ext_sd <= 1'b1;
    repeat (10) @(posedge aclk);
    check(lnk, 1'b0);
    repeat (30) @(posedge aclk);
    check(lnk, 1'b1);
    repeat (4) partner.send_ones(84, 1'b1);
    settle();
    axi_read({`FPRC_IDX_STATUS, 2'b00});
    check(rd & 32'h0000_0014, 32'h0000_0014);
    send_jk();
    settle();
    check(dv, 1'b0);
    partner.send_ones(90, 1'b0);
    // The read made during the fault could not clear the flag
    axi_read({`FPRC_IDX_STATUS, 2'b00});
    check(rd[`FPRC_ST_RFAULT], 1'b1);
    axi_read({`FPRC_IDX_STATUS, 2'b00});
    check(rd[`FPRC_ST_RFAULT], 1'b0);
    tx_en <= 1'b1;
    repeat (8) @(posedge aclk);
    check(crs, 1'b1);
    axi_write({`FPRC_IDX_CONFIG, 2'b00}, 32'h0000_000e);
    repeat (8) @(posedge aclk);
    check(crs, 1'b0);
    w_strb <= 4'he;
    axi_write({`FPRC_IDX_CONFIG, 2'b00}, 32'h0000_0000);
    axi_read({`FPRC_IDX_CONFIG, 2'b00});
    check(rd, 32'h0000_000e);
    results();
  end
endmodule // testbench
